/* mmw_pkg.sv */
// Shared constants, state type and frame check function for the mapped register writer.
package mmw_pkg;

  // ==========================================================================
  // Frame layout
  localparam logic [7:0]  STN_MIN       = 8'h01;
  localparam logic [7:0]  STN_MAX       = 8'hf7;
  localparam logic [7:0]  FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0]  FC_WRITE_MANY = 8'h10;
  localparam logic [15:0] WIN_LO        = 16'h4e20;
  localparam logic [15:0] WIN_HI        = 16'h501c;
  localparam logic [7:0]  LEN_ONE       = 8'h08;
  localparam logic [7:0]  LEN_MANY_FIX  = 8'h09;
  localparam logic [7:0]  POS_ADDR      = 8'h00;
  localparam logic [7:0]  POS_VAL_ONE   = 8'h04;
  localparam logic [7:0]  POS_VAL_MANY  = 8'h07;
  localparam logic [7:0]  HDR_BYTES     = 8'h07;
  localparam logic [3:0]  REPLY_HDR     = 4'h6;
  localparam logic [3:0]  REPLY_LAST    = 4'h7;

  // ==========================================================================
  // Check sequence
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

  // ==========================================================================
  // Network master side
  localparam int          NUM_EP        = 5;
  localparam logic [15:0] COIL_ON       = 16'hff00;
  localparam logic [15:0] COIL_OFF      = 16'h0000;

  // ==========================================================================
  // Sequencer states, Gray along receive, push, reply
  typedef enum logic [1:0] {
    MMW_RX   = 2'b00,
    MMW_PUSH = 2'b01,
    MMW_TX   = 2'b11
  } mmw_state_t;

  // ==========================================================================
  // One byte step of the reflected check sequence, low bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte

endpackage : mmw_pkg

/* mmw_fifo_if.sv */
// Valid/ready carrier between the writer and its downstream write buffer.
`timescale 1ns/1ps
interface mmw_fifo_if #(parameter int WIDTH = 33);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : mmw_fifo_if

/* mmw_fifo.sv */
// Synchronous FIFO with valid/ready on both sides for downstream writes.
`timescale 1ns/1ps
module mmw_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Filling side
  mmw_fifo_if.snk               in_if,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  assign in_if.ready = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign do_push     = in_if.valid && in_if.ready;
  assign do_pop      = out_valid_o && out_ready_i;

  // ==========================================================================
  // Storage
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_if.data;
    end
  end

  // ==========================================================================
  // Pointers and fill level
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : mmw_fifo

/* mmw_writer.sv */
// Serial slave frame handler for mapped register writes plus network master helpers.
`timescale 1ns/1ps
module mmw_writer #(
  parameter int MAX_REGS   = 8,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic                        clk_sys_i,
  input  wire logic                        sys_rst_i,
  // Configuration
  input  wire logic [7:0]                  stn_addr_i,
  // Received byte stream from the serial receiver
  input  wire logic                        rx_valid_i,
  input  wire logic [7:0]                  rx_byte_i,
  input  wire logic                        frame_gap_i,
  // Reply byte stream to the serial transmitter
  output logic                             tx_valid_o,
  output logic [7:0]                       tx_byte_o,
  input  wire logic                        tx_ready_i,
  // Mapping table lookup
  output logic [15:0]                      map_addr_o,
  input  wire logic                        map_slave_ok_i,
  input  wire logic                        map_signed_i,
  input  wire logic                        map_swap_i,
  // Downstream write requests
  output logic                             ds_valid_o,
  input  wire logic                        ds_ready_i,
  output logic [15:0]                      ds_addr_o,
  output logic [15:0]                      ds_data_o,
  output logic                             ds_signed_o,
  // Network master poll results
  input  wire logic                        poll_valid_i,
  input  wire logic [2:0]                  poll_slot_i,
  input  wire logic [15:0]                 poll_data_i,
  input  wire logic [16*mmw_pkg::NUM_EP-1:0] thr_hi_i,
  input  wire logic [16*mmw_pkg::NUM_EP-1:0] thr_lo_i,
  input  wire logic [mmw_pkg::NUM_EP-1:0]  type_nc_i,
  output logic [16*mmw_pkg::NUM_EP-1:0]    mirror_o,
  output logic [mmw_pkg::NUM_EP-1:0]       alarm_o,
  // Network master coil writes
  input  wire logic                        coil_req_i,
  input  wire logic [2:0]                  coil_slot_i,
  input  wire logic [15:0]                 coil_addr_i,
  input  wire logic                        coil_on_i,
  output logic                             coil_valid_o,
  input  wire logic                        coil_ready_i,
  output logic [2:0]                       coil_slot_o,
  output logic [15:0]                      coil_addr_o,
  output logic [15:0]                      coil_value_o
);

  localparam int          PB      = 2 * MAX_REGS;
  localparam logic [7:0]  MAX_LEN = 8'(9 + PB);

  // ==========================================================================
  // Declarations
  mmw_pkg::mmw_state_t state;
  logic [7:0]          hdr [0:6];
  logic [7:0]          pbytes [0:PB-1];
  logic [7:0]          idx;
  logic [15:0]         rx_crc;
  logic                drop;
  logic [15:0]         start_addr;
  logic [15:0]         qty;
  logic [15:0]         last_addr;
  logic [7:0]          exp_len;
  logic                fc_one;
  logic                fc_many;
  logic                stn_ok;
  logic                frame_ok;
  logic                take_byte;
  logic [7:0]          vpos;
  logic                vpos_ok;
  logic [15:0]         k;
  logic [15:0]         cur_val;
  logic                push_done;
  logic [3:0]          tx_cnt;
  logic [15:0]         tx_crc;
  logic [15:0]         tx_crc_next;
  logic                tx_step;
  // One process per slot owns each element, so no packed vector has two writers.
  logic [15:0]         mir_arr [0:mmw_pkg::NUM_EP-1];
  logic                alm_arr [0:mmw_pkg::NUM_EP-1];

  mmw_fifo_if #(.WIDTH(33)) wr_if ();

  // ==========================================================================
  // Frame decode
  assign stn_ok     = (stn_addr_i >= mmw_pkg::STN_MIN) && (stn_addr_i <= mmw_pkg::STN_MAX);
  assign fc_one     = (hdr[1] == mmw_pkg::FC_WRITE_ONE);
  assign fc_many    = (hdr[1] == mmw_pkg::FC_WRITE_MANY);
  assign start_addr = {hdr[2], hdr[3]};
  assign qty        = fc_one ? 16'h0001 : {hdr[4], hdr[5]};
  assign last_addr  = start_addr + qty - 16'h0001;
  assign exp_len    = fc_one ? mmw_pkg::LEN_ONE : mmw_pkg::LEN_MANY_FIX + 8'({qty[6:0], 1'b0});
  assign take_byte  = rx_valid_i && (state == mmw_pkg::MMW_RX) && !drop;

  // Value bytes land in one buffer for both function codes.
  always_comb begin
    vpos    = 8'h00;
    vpos_ok = 1'b0;
    if (fc_one && (idx >= mmw_pkg::POS_VAL_ONE) && (idx < mmw_pkg::POS_VAL_ONE + 8'h02)) begin
      vpos    = idx - mmw_pkg::POS_VAL_ONE;
      vpos_ok = 1'b1;
    end else if (fc_many && (idx >= mmw_pkg::POS_VAL_MANY)
                 && (idx < mmw_pkg::POS_VAL_MANY + 8'(PB))) begin
      vpos    = idx - mmw_pkg::POS_VAL_MANY;
      vpos_ok = 1'b1;
    end
  end

  // A frame is accepted only if every check holds; anything else is silently dropped.
  assign frame_ok = !drop && (rx_crc == mmw_pkg::CRC_RESIDUE)
                    && (fc_one || fc_many) && (idx == exp_len)
                    && (qty != 16'h0000) && (qty <= 16'(MAX_REGS))
                    && (fc_one || (hdr[6] == 8'({qty[6:0], 1'b0})))
                    && (start_addr >= mmw_pkg::WIN_LO) && (last_addr <= mmw_pkg::WIN_HI)
                    && (last_addr >= start_addr);

  // ==========================================================================
  // Receive collection
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx    <= 8'h00;
      rx_crc <= mmw_pkg::CRC_INIT;
      drop   <= 1'b0;
    end else if (frame_gap_i || state != mmw_pkg::MMW_RX) begin
      idx    <= 8'h00;
      rx_crc <= mmw_pkg::CRC_INIT;
      drop   <= 1'b0;
    end else if (take_byte) begin
      rx_crc <= mmw_pkg::crc_byte(rx_crc, rx_byte_i);
      idx    <= idx + 8'h01;
      if (idx == mmw_pkg::POS_ADDR && (!stn_ok || rx_byte_i != stn_addr_i)) begin
        drop <= 1'b1;
      end
      if (idx >= MAX_LEN) begin
        drop <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (take_byte && idx < mmw_pkg::HDR_BYTES) begin
      hdr[idx[2:0]] <= rx_byte_i;
    end
    if (take_byte && vpos_ok) begin
      pbytes[vpos[$clog2(PB)-1:0]] <= rx_byte_i;
    end
  end

  // ==========================================================================
  // Sequencer
  assign push_done = (k == qty - 16'h0001) && (!map_slave_ok_i || wr_if.ready);
  assign tx_step   = tx_valid_o && tx_ready_i;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= mmw_pkg::MMW_RX;
    end else begin
      unique case (state)
        mmw_pkg::MMW_RX: begin
          if (frame_gap_i && frame_ok) begin
            state <= mmw_pkg::MMW_PUSH;
          end
        end
        mmw_pkg::MMW_PUSH: begin
          if (push_done) begin
            state <= mmw_pkg::MMW_TX;
          end
        end
        mmw_pkg::MMW_TX: begin
          if (tx_step && tx_cnt == mmw_pkg::REPLY_LAST) begin
            state <= mmw_pkg::MMW_RX;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Downstream forwarding
  // A full buffer holds the sequencer here, so no write is ever lost.
  assign map_addr_o = start_addr + k;
  assign cur_val    = {pbytes[2*k[$clog2(MAX_REGS)-1:0]], pbytes[2*k[$clog2(MAX_REGS)-1:0]+1]};
  assign wr_if.valid = (state == mmw_pkg::MMW_PUSH) && map_slave_ok_i;
  assign wr_if.data  = {map_signed_i, map_addr_o,
                        map_swap_i ? {cur_val[7:0], cur_val[15:8]} : cur_val};

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      k <= 16'h0000;
    end else if (state != mmw_pkg::MMW_PUSH || push_done) begin
      k <= 16'h0000;
    end else if (!map_slave_ok_i || wr_if.ready) begin
      k <= k + 16'h0001;
    end
  end

  mmw_fifo #(
    .WIDTH (33),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_if       (wr_if),
    .out_valid_o (ds_valid_o),
    .out_ready_i (ds_ready_i),
    .out_data_o  ({ds_signed_o, ds_addr_o, ds_data_o})
  );

  // ==========================================================================
  // Reply
  // The reply check is recomputed rather than copied, which gives the exact echo for a
  // single write and the correct trailer for a multiple write.
  assign tx_crc_next = mmw_pkg::crc_byte(tx_crc, tx_byte_o);
  assign tx_valid_o  = (state == mmw_pkg::MMW_TX);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_cnt    <= 4'h0;
      tx_crc    <= mmw_pkg::CRC_INIT;
      tx_byte_o <= 8'h00;
    end else if (state != mmw_pkg::MMW_TX) begin
      tx_cnt    <= 4'h0;
      tx_crc    <= mmw_pkg::CRC_INIT;
      tx_byte_o <= hdr[0];
    end else if (tx_step) begin
      tx_cnt <= tx_cnt + 4'h1;
      if (tx_cnt < mmw_pkg::REPLY_HDR) begin
        tx_crc <= tx_crc_next;
      end
      if (tx_cnt + 4'h1 < mmw_pkg::REPLY_HDR) begin
        tx_byte_o <= hdr[3'(tx_cnt + 4'h1)];
      end else if (tx_cnt + 4'h1 == mmw_pkg::REPLY_HDR) begin
        tx_byte_o <= tx_crc_next[7:0];
      end else begin
        tx_byte_o <= tx_crc[15:8];
      end
    end
  end

  // ==========================================================================
  // Network master mirror and limit alarms
  // Slot numbers of five and above do not exist and are ignored.
  generate
    for (genvar s = 0; s < mmw_pkg::NUM_EP; s++) begin : g_ep
      logic [15:0] hi;
      logic [15:0] lo;
      logic        out_of_band;
      assign hi          = thr_hi_i[16*s +: 16];
      assign lo          = thr_lo_i[16*s +: 16];
      assign out_of_band = (mir_arr[s] > hi) || (mir_arr[s] < lo);

      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          mir_arr[s] <= 16'h0000;
        end else if (poll_valid_i && poll_slot_i == 3'(s)) begin
          mir_arr[s] <= poll_data_i;
        end
      end

      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          alm_arr[s] <= 1'b0;
        end else begin
          alm_arr[s] <= type_nc_i[s] ? !out_of_band : out_of_band;
        end
      end
    end
  endgenerate

  always_comb begin
    for (int e = 0; e < mmw_pkg::NUM_EP; e++) begin
      mirror_o[16*e +: 16] = mir_arr[e];
      alarm_o[e]           = alm_arr[e];
    end
  end

  // ==========================================================================
  // Network master coil writes
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      coil_valid_o <= 1'b0;
      coil_slot_o  <= 3'h0;
      coil_addr_o  <= 16'h0000;
      coil_value_o <= mmw_pkg::COIL_OFF;
    end else if (coil_valid_o && !coil_ready_i) begin
      coil_valid_o <= 1'b1;
    end else if (coil_req_i && coil_slot_i < 3'(mmw_pkg::NUM_EP)) begin
      coil_valid_o <= 1'b1;
      coil_slot_o  <= coil_slot_i;
      coil_addr_o  <= coil_addr_i;
      coil_value_o <= coil_on_i ? mmw_pkg::COIL_ON : mmw_pkg::COIL_OFF;
    end else begin
      coil_valid_o <= 1'b0;
    end
  end

endmodule : mmw_writer

/* mmw_writer_properties.sv */
// Concurrent checks on the ports of the mapped register writer.
`timescale 1ns/1ps
module mmw_writer_properties (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  // Serial side
  input wire logic [7:0]  stn_addr_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_byte_i,
  input wire logic        frame_gap_i,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_byte_o,
  input wire logic        tx_ready_i,
  // Downstream writes
  input wire logic        ds_valid_o,
  input wire logic        ds_ready_i,
  input wire logic [15:0] ds_addr_o,
  input wire logic [15:0] ds_data_o,
  // Network master
  input wire logic        poll_valid_i,
  input wire logic [2:0]  poll_slot_i,
  input wire logic [15:0] poll_data_i,
  input wire logic [79:0] mirror_o,
  input wire logic        coil_req_i,
  input wire logic [2:0]  coil_slot_i,
  input wire logic [15:0] coil_addr_i,
  input wire logic        coil_on_i,
  input wire logic        coil_valid_o,
  input wire logic        coil_ready_i,
  input wire logic [2:0]  coil_slot_o,
  input wire logic [15:0] coil_addr_o,
  input wire logic [15:0] coil_value_o
);
  // ==========================================================================
  // Helper state
  logic       at_start;
  logic [7:0] first_b;
  logic [2:0] slot_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) at_start <= 1'b1;
    else if (frame_gap_i) at_start <= 1'b1;
    else if (rx_valid_i) at_start <= 1'b0;
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) first_b <= 8'h00;
    else if (rx_valid_i && at_start) first_b <= rx_byte_i;
  end
  always_ff @(posedge clk_sys_i) begin
    slot_q <= poll_slot_i;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================================
  // Assertions
  chk_addr_match: assert property (
    frame_gap_i && first_b != stn_addr_i && !tx_valid_o |=> !tx_valid_o [*4])
    else $error("reply to a foreign station");
  chk_first_echo: assert property (
    $rose(tx_valid_o) |-> tx_byte_o == stn_addr_i)
    else $error("reply does not open with the station");
  chk_tx_hold: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
    else $error("reply byte dropped while stalled");
  chk_ds_hold: assert property (
    ds_valid_o && !ds_ready_i |=> ds_valid_o && $stable({ds_addr_o, ds_data_o}))
    else $error("downstream write changed while stalled");
  chk_mirror_upd: assert property (
    poll_valid_i && poll_slot_i < 3'h5 |=> mirror_o[16*slot_q +: 16] == $past(poll_data_i))
    else $error("mirror not updated");
  chk_coil_issue: assert property (
    coil_req_i && !coil_valid_o && coil_slot_i < 3'h5 |=> coil_valid_o
      && coil_slot_o == $past(coil_slot_i) && coil_addr_o == $past(coil_addr_i)
      && coil_value_o == ($past(coil_on_i) ? mmw_pkg::COIL_ON : mmw_pkg::COIL_OFF))
    else $error("coil write not issued");
  chk_coil_slot: assert property (
    coil_req_i && !coil_valid_o && coil_slot_i > 3'h4 |=> !coil_valid_o)
    else $error("coil write to a missing endpoint");
  chk_coil_hold: assert property (
    coil_valid_o && !coil_ready_i |=> coil_valid_o && $stable(coil_addr_o))
    else $error("coil write dropped while stalled");
endmodule : mmw_writer_properties

bind mmw_writer mmw_writer_properties u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .stn_addr_i(stn_addr_i),
  .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .frame_gap_i(frame_gap_i),
  .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i),
  .ds_valid_o(ds_valid_o), .ds_ready_i(ds_ready_i), .ds_addr_o(ds_addr_o),
  .ds_data_o(ds_data_o), .poll_valid_i(poll_valid_i), .poll_slot_i(poll_slot_i),
  .poll_data_i(poll_data_i), .mirror_o(mirror_o), .coil_req_i(coil_req_i),
  .coil_slot_i(coil_slot_i), .coil_addr_i(coil_addr_i), .coil_on_i(coil_on_i),
  .coil_valid_o(coil_valid_o), .coil_ready_i(coil_ready_i), .coil_slot_o(coil_slot_o),
  .coil_addr_o(coil_addr_o), .coil_value_o(coil_value_o));

/* mmw_far_side.sv */
// Far side model: reply transmitter, downstream slaves, mapping table and coil target.
`timescale 1ns/1ps
module mmw_far_side (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  // Mapping table lookup
  input  wire logic [15:0] map_addr_i,
  output logic             map_slave_ok_o,
  output logic             map_signed_o,
  output logic             map_swap_o,
  // Acceptance
  output logic             tx_ready_o,
  output logic             ds_ready_o,
  output logic             coil_ready_o
);
  // Addresses ending in f are left out of the slave list, so skipping is seen.
  assign map_slave_ok_o = map_addr_i[3:0] != 4'hf;
  assign map_signed_o   = map_addr_i[1];
  assign map_swap_o     = map_addr_i[0];
  // The slaves are slow on purpose so that the write buffer fills up.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_ready_o   <= 1'b0;
      ds_ready_o   <= 1'b0;
      coil_ready_o <= 1'b0;
    end else begin
      tx_ready_o   <= ($urandom % 4) != 0;
      ds_ready_o   <= ($urandom % 8) == 0;
      coil_ready_o <= ($urandom % 4) != 0;
    end
  end
endmodule : mmw_far_side

/* mmw_writer_bench.sv */
// Self-checking bench for the mapped register writer.
`timescale 1ns/1ps
module mmw_writer_bench;
  typedef logic [7:0] mmw_bq_t[$];
  typedef logic [32:0] mmw_dq_t[$];
  logic clk_sys_i, sys_rst_i, rx_valid_i, frame_gap_i, tx_valid_o, tx_ready_i;
  logic map_slave_ok_i, map_signed_i, map_swap_i, ds_valid_o, ds_ready_i, ds_signed_o;
  logic poll_valid_i, coil_req_i, coil_on_i, coil_valid_o, coil_ready_i;
  logic [7:0] stn_addr_i, rx_byte_i, tx_byte_o;
  logic [15:0] map_addr_o, ds_addr_o, ds_data_o, poll_data_i, coil_addr_i, coil_addr_o;
  logic [15:0] coil_value_o;
  logic [2:0] poll_slot_i, coil_slot_i, coil_slot_o;
  logic [79:0] thr_hi_i, thr_lo_i, mirror_o, m;
  logic [4:0] type_nc_i, alarm_o;
  int fails, checked, cyc, n, q;
  mmw_bq_t txq, f, none_b;
  mmw_dq_t dsq, none_d;
  logic [15:0] a, v;
  logic [7:0] s;
  logic [2:0] sl;

  mmw_writer DUT (.clk_sys_i, .sys_rst_i, .stn_addr_i, .rx_valid_i, .rx_byte_i,
    .frame_gap_i, .tx_valid_o, .tx_byte_o, .tx_ready_i, .map_addr_o, .map_slave_ok_i,
    .map_signed_i, .map_swap_i, .ds_valid_o, .ds_ready_i, .ds_addr_o, .ds_data_o,
    .ds_signed_o, .poll_valid_i, .poll_slot_i, .poll_data_i, .thr_hi_i, .thr_lo_i,
    .type_nc_i, .mirror_o, .alarm_o, .coil_req_i, .coil_slot_i, .coil_addr_i, .coil_on_i,
    .coil_valid_o, .coil_ready_i, .coil_slot_o, .coil_addr_o, .coil_value_o);
  mmw_far_side far (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .map_addr_i(map_addr_o),
    .map_slave_ok_o(map_slave_ok_i), .map_signed_o(map_signed_i), .map_swap_o(map_swap_i),
    .tx_ready_o(tx_ready_i), .ds_ready_o(ds_ready_i), .coil_ready_o(coil_ready_i));

  // ==========================================================================
  // Helpers
  task automatic end_sim();
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic mmw_bq_t crc_add(mmw_bq_t b);
    logic [15:0] c;
    c = mmw_pkg::CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ mmw_pkg::CRC_POLY) : (c >> 1);
    end
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    return b;
  endfunction : crc_add
  function automatic mmw_dq_t exp_ds(logic [15:0] a0, mmw_bq_t vb);
    mmw_dq_t r;
    logic [15:0] ad;
    for (int k = 0; k < vb.size() / 2; k++) begin
      ad = a0 + 16'(k);
      if (ad[3:0] != 4'hf) r.push_back({ad, ad[0] ? {vb[2*k+1], vb[2*k]} : {vb[2*k], vb[2*k+1]}, ad[1]});
    end
    return r;
  endfunction : exp_ds
  task automatic run(input mmw_bq_t fr, input mmw_bq_t er, input mmw_dq_t ed);
    txq.delete();
    dsq.delete();
    foreach (fr[i]) begin
      @(posedge clk_sys_i);
      rx_valid_i <= 1'b1;
      rx_byte_i  <= fr[i];
    end
    @(posedge clk_sys_i);
    rx_valid_i  <= 1'b0;
    frame_gap_i <= 1'b1;
    @(posedge clk_sys_i);
    frame_gap_i <= 1'b0;
    for (n = 0; n < 400 && (txq.size() < er.size() || dsq.size() < ed.size()); n++)
      @(posedge clk_sys_i);
    repeat (20) @(posedge clk_sys_i);
    chk("reply_len", er.size(), txq.size());
    foreach (er[i]) if (i < txq.size()) chk("reply_byte", er[i], txq[i]);
    chk("ds_len", ed.size(), dsq.size());
    foreach (ed[i]) if (i < dsq.size()) chk("ds_write", ed[i], dsq[i]);
  endtask : run

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Catches handshakes and bounds the run.
  always @(posedge clk_sys_i) begin
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) txq.push_back(tx_byte_o);
    if (ds_valid_o === 1'b1 && ds_ready_i === 1'b1) dsq.push_back({ds_addr_o, ds_data_o, ds_signed_o});
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(32'h8401));
    {sys_rst_i, stn_addr_i, rx_valid_i, rx_byte_i, frame_gap_i} = {1'b1, 8'h01, 10'h000};
    {poll_valid_i, poll_slot_i, poll_data_i, coil_req_i, coil_slot_i} = '0;
    {coil_addr_i, coil_on_i, type_nc_i} = '0;
    thr_hi_i = {5{16'd1000}};
    thr_lo_i = {5{16'd100}};
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    f = crc_add({8'h01, 8'h06, 8'h4e, 8'h20, 8'h00, 8'h64});
    chk("crc", 16'h9ec3, {f[6], f[7]});
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 8'h01 : (i == 1) ? 8'hf7 : 8'($urandom_range(1, 247));
      a = (i < 2) ? mmw_pkg::WIN_LO + 16'(i * 508) : (i == 2) ? 16'h4e2f : 16'($urandom_range(20000, 20508));
      v = (i == 0) ? 16'h0064 : 16'($urandom);
      stn_addr_i <= s;
      f = crc_add({s, 8'h06, a[15:8], a[7:0], v[15:8], v[7:0]});
      run(f, f, exp_ds(a, f[4:5]));
    end
    // Foreign station, bad check, window edges, wrong code, unusable station.
    for (int i = 0; i < 6; i++) begin
      stn_addr_i <= (i == 5) ? 8'h00 : 8'h05;
      a = (i == 2) ? 16'h501d : (i == 3) ? 16'h4e1f : 16'h4e21;
      f = crc_add({(i == 0) ? 8'h06 : (i == 5) ? 8'h00 : 8'h05, (i == 4) ? 8'h03 : 8'h06,
                   a[15:8], a[7:0], 8'h12, 8'h34});
      if (i == 1) f[7] = f[7] ^ 8'h01;
      run(f, none_b, none_d);
    end
    stn_addr_i <= 8'h11;
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'h501a : (i == 2) ? 16'h501b : 16'h4e2d;
      q = (i == 1) ? 8 : (i == 3) ? 9 : 3;
      f = {8'h11, 8'h10, a[15:8], a[7:0], 8'h00, 8'(q), 8'(2 * q)};
      for (int k = 0; k < 2 * q; k++) f.push_back(8'($urandom));
      if (i < 2) run(crc_add(f), crc_add(f[0:5]), exp_ds(a, f[7:6+2*q]));
      else run(crc_add(f), none_b, none_d);
    end
    type_nc_i <= 5'b01010;
    for (int i = 0; i < 11; i++) begin
      sl = (i == 10) ? 3'h5 : 3'(i % 5);
      v = (i == 0) ? 16'd1000 : (i == 1) ? 16'd100 : (i == 2) ? 16'd1001 : 16'($urandom_range(0, 1500));
      m = mirror_o;
      @(posedge clk_sys_i);
      {poll_valid_i, poll_slot_i, poll_data_i} <= {1'b1, sl, v};
      @(posedge clk_sys_i);
      poll_valid_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      if (i == 10) chk("mirror_skip", m[47:0], mirror_o[47:0]);
      if (i == 10) chk("mirror_skip_hi", m[79:48], mirror_o[79:48]);
      else chk("mirror", v, mirror_o[16*sl +: 16]);
      if (i < 10) chk("alarm", ((v > 16'd1000 || v < 16'd100) ^ type_nc_i[sl]), alarm_o[sl]);
    end
    for (int i = 0; i < 4; i++) begin
      sl = (i == 3) ? 3'h6 : 3'(2 * i);
      v = a;
      a = 16'($urandom);
      @(posedge clk_sys_i);
      {coil_req_i, coil_slot_i, coil_addr_i, coil_on_i} <= {1'b1, sl, a, i[0]};
      @(posedge clk_sys_i);
      coil_req_i <= 1'b0;
      #1;
      chk("coil_valid", i != 3, coil_valid_o);
      chk("coil_req", (i == 3) ? {3'h4, v, 16'h0000} : {sl, a, i[0] ? 16'hff00 : 16'h0000},
          {coil_slot_o, coil_addr_o, coil_value_o});
      for (n = 0; n < 50 && coil_valid_o !== 1'b0; n++) begin
        @(posedge clk_sys_i);
        #1;
      end
    end
    end_sim();
  end
endmodule : mmw_writer_bench
